// [wakeup_cfg.svh]
/*
 * Constants for the low-power wake-up and vector selection block.
 * Assumes inclusion by bare name from the design modules and the bench.
 */
`ifndef WAKEUP_CFG_SVH
`define WAKEUP_CFG_SVH

`define VEC_RESET 16'hfffe
`define VEC_BREAK 16'hfffc
`define VEC_EXTIRQ 16'hfffa
`define VEC_CLKGEN 16'hfff8
`define VEC_T1_CH0 16'hfff6
`define VEC_T1_CH1 16'hfff4
`define VEC_T1_OVF 16'hfff2
`define VEC_T2_CH0 16'hfff0
`define VEC_T2_CH1 16'hffee
`define VEC_T2_OVF 16'hffec
`define VEC_SPI_RX 16'hffea
`define VEC_SPI_TX 16'hffe8
`define VEC_SER_ERR 16'hffe6
`define VEC_SER_RX 16'hffe4
`define VEC_SER_TX 16'hffe2
`define VEC_KEYPAD 16'hffe0
`define VEC_ADC 16'hffde
`define VEC_WAKE_TMR 16'hffdc

`define REC_LONG_CYCLES 13'h1000
`define REC_SHORT_CYCLES 13'h0020

`define SRC_T1_OVF 0
`define SRC_T1_CH1 1
`define SRC_T1_CH0 2
`define SRC_T2_OVF 3
`define SRC_T2_CH1 4
`define SRC_T2_CH0 5
`define SRC_SPI_TX 6
`define SRC_SPI_RX 7
`define SRC_SER_TX 8
`define SRC_SER_RX 9
`define SRC_SER_ERR 10
`define SRC_ADC 11
`define SRC_CLKGEN 12
`define SRC_COUNT 13

`endif

// [wakeup_pkg.sv]
/*
 * Types for the low-power wake-up and vector selection block.
 * Assumes nothing beyond the constants header.
 */
package wakeup_pkg;
    typedef enum logic [2:0] {
        RUN = 3'b000,
        WAITING = 3'b001,
        STOPPED = 3'b010,
        RECOVER = 3'b011,
        FETCH = 3'b100
    } power_state_e;
    typedef logic [15:0] vector_t;
endpackage

// [recovery_counter.sv]
/*
 * Stop-recovery down counter, advanced by the crystal reference enable.
 * Assumes start is a one-cycle pulse on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_cfg.svh"

module recovery_counter #(
    parameter int LONG_CYCLES = 4096,
    parameter int SHORT_CYCLES = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic shortSel,
    input wire logic tick,
    output logic done
);
    logic [12:0] count;
    logic running;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 13'h0000;
            running <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            count <= shortSel ? 13'(SHORT_CYCLES) : 13'(LONG_CYCLES);
            running <= 1'b1;
            done <= 1'b0;
        end else if (running && tick) begin
            if (count == 13'h0001) begin
                running <= 1'b0;
                done <= 1'b1;
            end
            count <= count - 13'h0001;
        end else begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [low_power_wakeup_vectoring.sv]
/*
 * Wait and stop wake-up sequencing with vector selection and stop recovery.
 * Assumes event inputs other than the wake timer rollover come from pins or other domains and are synchronised here;
 * crystalTick is a one-cycle enable marking each crystal reference clock cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_cfg.svh"

module low_power_wakeup_vectoring #(
    parameter int LONG_RECOVERY = 4096,
    parameter int SHORT_RECOVERY = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic waitReq,
    input wire logic stopReq,
    input wire logic osc_run_in_stop,
    input wire logic short_recovery_select,
    input wire logic crystalTick,
    input wire logic resetPinLow,
    input wire logic watchdogTimeout,
    input wire logic undervoltageTrip,
    input wire logic extIrqPin,
    input wire logic keypadPin,
    input wire logic breakIrq,
    input wire logic wakeTimerRollover,
    input wire logic [`SRC_COUNT-1:0] periphIrq,
    output logic coreClkEn,
    output logic sysClkEn,
    output logic timerRun,
    output logic wakeTimerRun,
    output logic wakeTimerAccess,
    output logic wakeTimerIrq,
    output logic deviceReset,
    output logic vectorValid,
    output logic [15:0] vectorAddr,
    output logic lowPower
);
    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    localparam int NSYNC = `SRC_COUNT + 10;
    // Each stage resets to its input's idle level: the two interrupt pins idle high,
    // every request idles low, so releasing reset raises no event
    localparam logic [NSYNC-1:0] IDLE_LEVEL = NSYNC'(3'h6);
    logic [NSYNC-1:0] rawIn;
    logic [NSYNC-1:0] syncA;
    logic [NSYNC-1:0] syncB;

    assign rawIn = {periphIrq, waitReq, stopReq, osc_run_in_stop, short_recovery_select,
                    resetPinLow, watchdogTimeout, undervoltageTrip, extIrqPin, keypadPin,
                    breakIrq};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    syncA[gi] <= IDLE_LEVEL[gi];
                    syncB[gi] <= IDLE_LEVEL[gi];
                end else begin
                    syncA[gi] <= rawIn[gi];
                    syncB[gi] <= syncA[gi];
                end
            end
        end
    endgenerate

    logic [`SRC_COUNT-1:0] irqS;
    logic waitS, stopS, oscS, shortS, rstPinS, wdogS, uvS, extS, keyS, brkS;
    assign {irqS, waitS, stopS, oscS, shortS, rstPinS, wdogS, uvS, extS, keyS, brkS} = syncB;

    // Wake timer rollover is on-chip logic on this clock and needs no sync
    logic extPrev, keyPrev;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            extPrev <= 1'b1;
            keyPrev <= 1'b1;
        end else begin
            extPrev <= extS;
            keyPrev <= keyS;
        end
    end

    logic extFall, keyFall, resetEvent;
    assign extFall = extPrev & ~extS;
    assign keyFall = keyPrev & ~keyS;
    assign resetEvent = rstPinS | wdogS | uvS;

    ////////////////////////////////////////////////////////////////////////////
    // Vector selection, highest priority first
    logic periphAny;
    logic [15:0] periphVec;
    assign periphAny = |irqS;

    always_comb begin
        periphVec = `VEC_ADC;
        if (irqS[`SRC_T1_OVF]) periphVec = `VEC_T1_OVF;
        else if (irqS[`SRC_T1_CH1]) periphVec = `VEC_T1_CH1;
        else if (irqS[`SRC_T1_CH0]) periphVec = `VEC_T1_CH0;
        else if (irqS[`SRC_T2_OVF]) periphVec = `VEC_T2_OVF;
        else if (irqS[`SRC_T2_CH1]) periphVec = `VEC_T2_CH1;
        else if (irqS[`SRC_T2_CH0]) periphVec = `VEC_T2_CH0;
        else if (irqS[`SRC_SPI_TX]) periphVec = `VEC_SPI_TX;
        else if (irqS[`SRC_SPI_RX]) periphVec = `VEC_SPI_RX;
        else if (irqS[`SRC_SER_TX]) periphVec = `VEC_SER_TX;
        else if (irqS[`SRC_SER_RX]) periphVec = `VEC_SER_RX;
        else if (irqS[`SRC_SER_ERR]) periphVec = `VEC_SER_ERR;
        else if (irqS[`SRC_CLKGEN]) periphVec = `VEC_CLKGEN;
        else periphVec = `VEC_ADC;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state machine
    wakeup_pkg::power_state_e state;
    logic [15:0] pendVec;
    logic recStart;
    logic recDone;
    logic wakeTimerActive;
    logic resetArmed;

    // State decode shared by the transition and output logic
    logic inRun;
    logic inWait;
    logic inStop;
    logic inRecover;
    logic inFetch;
    assign inRun = state == wakeup_pkg::RUN;
    assign inWait = state == wakeup_pkg::WAITING;
    assign inStop = state == wakeup_pkg::STOPPED;
    assign inRecover = state == wakeup_pkg::RECOVER;
    assign inFetch = state == wakeup_pkg::FETCH;

    // A reset source still held after its fetch must not fetch again from run; wait and stop do not check this
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            resetArmed <= 1'b1;
        end else if (!resetEvent) begin
            resetArmed <= 1'b1;
        end else if (inFetch && pendVec == `VEC_RESET) begin
            resetArmed <= 1'b0;
        end
    end

    // wake timer in stop only with oscillator
    assign wakeTimerActive = !inStop || oscS;

    logic waitWake, stopWake;
    logic [15:0] waitVec, stopVec;

    always_comb begin
        waitWake = 1'b1;
        if (resetEvent) waitVec = `VEC_RESET;
        else if (brkS) waitVec = `VEC_BREAK;
        else if (extFall) waitVec = `VEC_EXTIRQ;
        else if (keyFall) waitVec = `VEC_KEYPAD;
        else if (wakeTimerRollover) waitVec = `VEC_WAKE_TMR;
        else if (periphAny) waitVec = periphVec;
        else begin
            waitVec = `VEC_RESET;
            waitWake = 1'b0;
        end
    end

    always_comb begin
        stopWake = 1'b1;
        if (rstPinS || uvS) stopVec = `VEC_RESET;
        else if (brkS) stopVec = `VEC_BREAK;
        else if (extFall) stopVec = `VEC_EXTIRQ;
        else if (keyFall) stopVec = `VEC_KEYPAD;
        else if (wakeTimerRollover && oscS) stopVec = `VEC_WAKE_TMR;
        else begin
            stopVec = `VEC_RESET;
            stopWake = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= wakeup_pkg::RUN;
            pendVec <= `VEC_RESET;
        end else begin
            case (state)
                wakeup_pkg::RUN: begin
                    if (resetEvent && resetArmed) begin
                        pendVec <= `VEC_RESET;
                        state <= wakeup_pkg::FETCH;
                    end else if (stopS) begin
                        state <= wakeup_pkg::STOPPED;
                    end else if (waitS) begin
                        state <= wakeup_pkg::WAITING;
                    end
                end
                wakeup_pkg::WAITING: begin
                    if (waitWake) begin
                        pendVec <= waitVec;
                        state <= wakeup_pkg::FETCH;
                    end
                end
                wakeup_pkg::STOPPED: begin
                    if (stopWake) begin
                        pendVec <= stopVec;
                        state <= wakeup_pkg::RECOVER;
                    end
                end
                wakeup_pkg::RECOVER: begin
                    if (recDone) begin
                        state <= wakeup_pkg::FETCH;
                    end
                end
                wakeup_pkg::FETCH: begin
                    state <= wakeup_pkg::RUN;
                end
                default: begin
                    state <= wakeup_pkg::RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            recStart <= 1'b0;
        end else begin
            recStart <= inStop && stopWake;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Recovery counter
    recovery_counter #(
        .LONG_CYCLES(LONG_RECOVERY),
        .SHORT_CYCLES(SHORT_RECOVERY)
    ) u_rec (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(recStart),
        .shortSel(shortS),
        .tick(crystalTick),
        .done(recDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs: clock gating and low-power status
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            coreClkEn <= 1'b1;
            sysClkEn <= 1'b1;
            lowPower <= 1'b0;
        end else begin
            coreClkEn <= inRun || inFetch;
            sysClkEn <= !((inStop && !oscS) || inRecover);
            lowPower <= inWait || inStop || inRecover;
        end
    end

    // Timer units hold their state while stopped or recovering
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            timerRun <= 1'b1;
        end else begin
            // timers frozen in stop and recovery
            timerRun <= !(inStop || inRecover);
        end
    end

    // Periodic wake timer run, access and interrupt
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wakeTimerRun <= 1'b1;
            wakeTimerAccess <= 1'b1;
            wakeTimerIrq <= 1'b0;
        end else begin
            // wake timer runs in wait, no access
            wakeTimerRun <= wakeTimerActive && !inRecover;
            wakeTimerAccess <= inRun || inFetch;
            wakeTimerIrq <= wakeTimerRollover && wakeTimerActive;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Vector hand-over to the core
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vectorValid <= 1'b0;
            vectorAddr <= `VEC_RESET;
        end else begin
            vectorValid <= inFetch;
            if (inFetch) begin
                vectorAddr <= pendVec;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            deviceReset <= 1'b0;
        end else begin
            deviceReset <= inFetch && (pendVec == `VEC_RESET);
        end
    end
endmodule
`default_nettype wire

// [core_irq_model.sv]
/* Processor core side: raises wait or stop requests and supplies the crystal tick.
   Assumes the bench pulses enterWait or enterStop for one cycle. */
`timescale 1ns/1ps
`default_nettype none
module core_irq_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enterWait,
    input wire logic enterStop,
    input wire logic lowPower,
    output logic waitReq,
    output logic stopReq,
    output logic crystalTick
);
////////////////////////////////////////
    // Request held until the block reports low power
    always_ff @(posedge ref_clk) begin
        if (rst || lowPower) begin
            waitReq <= 1'b0;
            stopReq <= 1'b0;
        end else if (enterWait || enterStop) begin
            waitReq <= enterWait;
            stopReq <= enterStop;
        end
    end
    always_ff @(posedge ref_clk) begin
        crystalTick <= !rst;
    end
endmodule
`default_nettype wire

// [wakeup_monitor.sv]
/* Concurrent checks on the wake-up block's ports.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module wakeup_monitor #(
    parameter int LONG_RECOVERY = 4096,
    parameter int SHORT_RECOVERY = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic osc_run_in_stop,
    input wire logic resetPinLow,
    input wire logic wakeTimerRollover,
    input wire logic coreClkEn,
    input wire logic sysClkEn,
    input wire logic timerRun,
    input wire logic wakeTimerRun,
    input wire logic wakeTimerAccess,
    input wire logic wakeTimerIrq,
    input wire logic deviceReset,
    input wire logic vectorValid,
    input wire logic [15:0] vectorAddr,
    input wire logic lowPower
);
////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_fetch(logic [15:0] a);
        vectorValid && vectorAddr == a;
    endsequence
    chk_fetch_pulse: assert property (vectorValid |=> !vectorValid)
        else $error("fetch pulse too long");
    chk_reset_vector: assert property (deviceReset |-> s_fetch(16'hfffe))
        else $error("reset without reset vector");
    chk_fetch_clocks: assert property (vectorValid |-> coreClkEn && sysClkEn && !lowPower)
        else $error("fetch before clocks released");
    chk_stop_timers: assert property (lowPower && !sysClkEn |-> !timerRun)
        else $error("timers running in stop");
    chk_access_blocked: assert property (lowPower |-> !wakeTimerAccess)
        else $error("wake timer access in low power");
    chk_osc_off: assert property (lowPower && !timerRun && !osc_run_in_stop |-> !sysClkEn && !wakeTimerRun)
        else $error("clocks alive in stop");
    chk_irq_cause: assert property (wakeTimerIrq |-> $past(wakeTimerRollover))
        else $error("wake irq without rollover");
    chk_wait_wake: assert property (wakeTimerIrq && $past(lowPower) && $past(timerRun) |-> ##[0:8] s_fetch(16'hffdc))
        else $error("wake timer did not end wait");
    chk_reset_wait: assert property ($rose(resetPinLow) && timerRun |-> ##[1:8] deviceReset)
        else $error("reset pin not honoured");
endmodule
bind low_power_wakeup_vectoring wakeup_monitor #(.LONG_RECOVERY(LONG_RECOVERY), .SHORT_RECOVERY(SHORT_RECOVERY)) mon (
    .ref_clk(ref_clk), .rst(rst), .osc_run_in_stop(osc_run_in_stop), .resetPinLow(resetPinLow),
    .wakeTimerRollover(wakeTimerRollover), .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .timerRun(timerRun),
    .wakeTimerRun(wakeTimerRun), .wakeTimerAccess(wakeTimerAccess), .wakeTimerIrq(wakeTimerIrq),
    .deviceReset(deviceReset), .vectorValid(vectorValid), .vectorAddr(vectorAddr), .lowPower(lowPower));
`default_nettype wire

// [tb.sv]
/* Self-checking bench for the wake-up block.
   Assumes the core model and monitor are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
`include "wakeup_cfg.svh"
module tb;
    logic ref_clk = 0, rst = 1, enterWait = 0, enterStop = 0, osc = 0, shortSel = 0;
    logic wdog = 0, rstPin = 0, uvTrip = 0, extPin = 1, keyPin = 1, brk = 0, roll = 0;
    logic [`SRC_COUNT-1:0] periph = '0;
    logic waitReq, stopReq, tick, coreClkEn, sysClkEn, timerRun, wtRun, wtAccess, wtIrq, devRst, vecValid, lowPower;
    logic [15:0] vecAddr;
    int fail_count = 0, n_compared = 0, cycles = 0;
    localparam logic [15:0] VECS [20] = '{16'hfff2, 16'hfff4, 16'hfff6, 16'hffec, 16'hffee, 16'hfff0, 16'hffe8,
        16'hffea, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffde, 16'hfff8, 16'hfffe, 16'hfffe, 16'hfffe, 16'hfffc,
        16'hfffa, 16'hffe0, 16'hffdc};
////////////////////////////////////////
    always #2.5 ref_clk = ~ref_clk;
    core_irq_model partner (.ref_clk(ref_clk), .rst(rst), .enterWait(enterWait), .enterStop(enterStop),
        .lowPower(lowPower), .waitReq(waitReq), .stopReq(stopReq), .crystalTick(tick));
    low_power_wakeup_vectoring #(.LONG_RECOVERY(8), .SHORT_RECOVERY(4)) dut (.ref_clk(ref_clk), .rst(rst),
        .waitReq(waitReq), .stopReq(stopReq), .osc_run_in_stop(osc), .short_recovery_select(shortSel),
        .crystalTick(tick), .resetPinLow(rstPin), .watchdogTimeout(wdog), .undervoltageTrip(uvTrip),
        .extIrqPin(extPin), .keypadPin(keyPin), .breakIrq(brk), .wakeTimerRollover(roll), .periphIrq(periph),
        .coreClkEn(coreClkEn), .sysClkEn(sysClkEn), .timerRun(timerRun), .wakeTimerRun(wtRun),
        .wakeTimerAccess(wtAccess), .wakeTimerIrq(wtIrq), .deviceReset(devRst), .vectorValid(vecValid),
        .vectorAddr(vecAddr), .lowPower(lowPower));
    task automatic end_of_test();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic drive_ev(input int e, input logic on);
        case (e)
            13: wdog = on;
            14: rstPin = on;
            15: uvTrip = on;
            16: brk = on;
            17: extPin = !on;
            18: keyPin = !on;
            19: roll = on;
            default: periph[e] = on;
        endcase
    endtask
    task automatic enter_low(input logic stp, input logic o, input logic s);
        int n;
        n = 0;
        osc = o;
        shortSel = s;
        enterStop = stp;
        enterWait = !stp;
        @(negedge ref_clk);
        enterStop = 0;
        enterWait = 0;
        while (lowPower !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (3) @(negedge ref_clk);
        chk(wtAccess, 1'b0);
        chk(timerRun, !stp);
        chk(wtRun, !stp || o);
        chk(sysClkEn, !stp || o);
        chk(coreClkEn, 1'b0);
    endtask
    task automatic exit_low(input int e, input logic [15:0] exp, output int lat);
        drive_ev(e, 1'b1);
        if (e == 19) begin
            @(negedge ref_clk);
            chk(wtIrq, 1'b1);
            drive_ev(e, 1'b0);
        end
        lat = 0;
        while (vecValid !== 1'b1 && lat < 80) begin
            @(negedge ref_clk);
            lat++;
        end
        chk(vecValid, 1'b1);
        chk(vecAddr, exp);
        chk(devRst, exp == 16'hfffe);
        chk(coreClkEn, 1'b1);
        drive_ev(e, 1'b0);
        repeat (8) @(negedge ref_clk);
    endtask
    task automatic test_reset_state();
        chk(vecAddr, 16'hfffe);
        chk(vecValid, 1'b0);
        chk(devRst, 1'b0);
        chk(lowPower, 1'b0);
        chk(wtAccess, 1'b1);
        chk(sysClkEn, 1'b1);
    endtask
    task automatic test_wait_sources();
        int lat;
        for (int i = 0; i < 20; i++) begin
            enter_low(1'b0, 1'b0, 1'b0);
            exit_low(i, VECS[i], lat);
        end
    endtask
    task automatic test_stop_sources();
        int lat;
        for (int i = 14; i < 20; i++) begin
            enter_low(1'b1, i == 19, 1'b1);
            exit_low(i, VECS[i], lat);
        end
    endtask
    task automatic test_stop_refusals();
        int lat;
        enter_low(1'b1, 1'b0, 1'b0);
        periph = '1;
        wdog = 1;
        roll = 1;
        @(negedge ref_clk);
        chk(wtIrq, 1'b0);
        roll = 0;
        repeat (30) @(negedge ref_clk);
        chk(lowPower, 1'b1);
        periph = '0;
        wdog = 0;
        exit_low(17, 16'hfffa, lat);
        chk(timerRun, 1'b1);
    endtask
    task automatic test_recovery_length();
        int longLat, shortLat;
        enter_low(1'b1, 1'b0, 1'b0);
        exit_low(18, 16'hffe0, longLat);
        enter_low(1'b1, 1'b0, 1'b1);
        exit_low(18, 16'hffe0, shortLat);
        chk(16'(longLat - shortLat), 16'h0004);
        // long recovery selected again after the short case
        shortSel = 0;
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 0;
        repeat (3) @(negedge ref_clk);
        test_reset_state();
        test_wait_sources();
        test_stop_sources();
        test_stop_refusals();
        test_recovery_length();
        end_of_test();
    end
endmodule
`default_nettype wire
